// *** apparent_energy_map.svh ***
/*
  Register offsets, field positions, reset values and timing counts for the
  apparent energy, power factor and harmonic distortion block.
  Assumes it is included by bare name before the module that uses it.
*/
`ifndef APPARENT_ENERGY_MAP_SVH
`define APPARENT_ENERGY_MAP_SVH

`define ADDR_PHASE_A_VOLTAGE_DISTORTION 16'he521
`define ADDR_PHASE_A_CURRENT_DISTORTION 16'he522
`define ADDR_PHASE_B_VOLTAGE_DISTORTION 16'he523
`define ADDR_PHASE_B_CURRENT_DISTORTION 16'he524
`define ADDR_PHASE_C_VOLTAGE_DISTORTION 16'he525
`define ADDR_PHASE_C_CURRENT_DISTORTION 16'he526
`define ADDR_PHASE_A_APPARENT_ENERGY    16'he40c
`define ADDR_PHASE_B_APPARENT_ENERGY    16'he40d
`define ADDR_PHASE_C_APPARENT_ENERGY    16'he40e
`define ADDR_HALF_CYCLE_COUNT           16'he60c
`define ADDR_COMPUTATION_MODE           16'he60e
`define ADDR_LINE_CYCLE_MODE            16'he702
`define ADDR_ACCUMULATION_MODE          16'he7f0
`define ADDR_PHASE_A_POWER_FACTOR       16'he902
`define ADDR_PHASE_B_POWER_FACTOR       16'he903
`define ADDR_PHASE_C_POWER_FACTOR       16'he904
`define ADDR_APPARENT_THRESHOLD         16'hea04
`define ADDR_PRIMARY_STATUS             16'he502
`define ADDR_PRIMARY_INTERRUPT_MASK     16'he50a

`define WIRING_SEL_LSB        4
`define LCM_ACTIVE_LINE_BIT   0
`define LCM_APPARENT_LINE_BIT 2
`define LCM_ZX_SEL_LSB        3
`define LCM_READ_CLEAR_BIT    6
`define LCM_PF_SOURCE_BIT     7
`define STATUS_HALF_FULL_BIT  4
`define ENERGY_HALF_BIT       30
`define THRESHOLD_ZERO_BITS   27

`define RST_THRESHOLD         8'h03
`define RST_COMPUTATION_MODE  16'h01ff
`define RST_LINE_CYCLE_MODE   8'h00
`define RST_ACCUMULATION_MODE 8'h00
`define RST_HALF_CYCLE_COUNT  16'h00ff

`define ACC_TICK_PERIOD_NS    976.5625
`define ACC_TICK_KHZ          1024
`define REF_CLK_KHZ           250000
`define VA_SHIFT              20

`define PF_PLUS_ONE           16'h7fff
`define PF_MINUS_ONE          16'h8000
`define THD_CLAMP             24'h7fffff

`endif

// *** apparent_energy_pkg.sv ***
/*
  Types shared by the apparent energy, power factor and distortion block.
  Assumes the front end delivers rms and power figures on ref_clk.
*/
package apparent_energy_pkg;

  typedef enum logic [1:0] {
    WIRING_STAR       = 2'b00,
    WIRING_THREE_WIRE = 2'b01,
    WIRING_RESERVED   = 2'b10,
    WIRING_NEG_A      = 2'b11
  } wiring_t;

  typedef struct packed {
    logic        [23:0] vrms;
    logic        [23:0] irms;
    logic        [23:0] fund_vrms;
    logic        [23:0] fund_irms;
    logic signed [23:0] active;
    logic signed [23:0] reactive;
    logic signed [23:0] fund_reactive;
  } phase_meas_t;

  typedef logic [31:0] energy_word_t;

endpackage

// *** apparent_energy_pf_thd.sv ***
/*
  Apparent energy accumulation, power factor and harmonic distortion results
  for three phases, with their configuration and result registers.
  Assumes the rms, power, zero crossing and no-load inputs come from logic on
  ref_clk, that dsp_update pulses once per 8 kHz DSP sample, and that the
  serial port front end presents one register access per reg_rd or reg_wr.
*/
// Notes on behaviour
// - Accumulate apparent power every 1.024 MHz tick.
// - Threshold is setting plus 27 zeros; pulse, subtract.
// - Energy registers are 32-bit, count first-stage pulses.
// - Wiring selection picks phase B accumulator inputs.
// - Three-wire: B voltage is A-C, B current zero.
// - Line-cycle bit transfers energies after half cycles.
// - Count selected zero crossings up to half_cycle_count.
// - Three bits pick phases counted, any combination.
// - Read-clear bit zeroes energy register after read.
// - Bit 30 change sets half-full flag, interrupt.
// - Power factor sign follows total reactive power.
// - Reactive no-load: sign taken from active power.
// - Power factor is signed 16-bit, 2^-15 weight.
// - Magnitude above one saturates by fundamental reactive.
// - Default power factor from instantaneous powers, 8 kHz.
// - Source bit, with active and apparent line-cycle bits set, uses line-cycle energies per count.
// - No-load forces power factor to one or zero.
// - Distortion is sqrt(total^2-fund^2) over fundamental.
// - Distortion is 3.21 signed, clamped at 3.9999.
// - Distortion reads as 32 bits, top byte zero.
`timescale 1ns/100ps
`include "apparent_energy_map.svh"

module apparent_energy_pf_thd (
  input  wire logic                                   ref_clk,
  input  wire logic                                   reset,
  input  wire logic [15:0]                            reg_addr,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  input  wire logic [31:0]                            reg_wdata,
  output logic      [31:0]                            reg_rdata,
  output logic                                        reg_rvalid,
  input  wire logic                                   dsp_update,
  input  wire apparent_energy_pkg::phase_meas_t [2:0] phase_in,
  input  wire logic [23:0]                            line_ac_rms,
  input  wire logic [2:0]                             zero_cross,
  input  wire apparent_energy_pkg::energy_word_t [2:0] active_line_energy,
  input  wire logic                                   no_load_enable,
  input  wire logic [2:0]                             apparent_no_load,
  input  wire logic [2:0]                             active_reactive_no_load,
  input  wire logic [2:0]                             reactive_no_load,
  output logic                                        irq_n,
  output logic      [2:0]                             apparent_pulse,
  output logic      [23:0]                            phase_b_voltage_rms_result
);
  import apparent_energy_pkg::*;

  localparam logic [15:0] ENERGY_ADDR [3] = '{`ADDR_PHASE_A_APPARENT_ENERGY,
                                              `ADDR_PHASE_B_APPARENT_ENERGY,
                                              `ADDR_PHASE_C_APPARENT_ENERGY};

  // Digit-by-digit integer square root.
  function automatic logic [23:0] isqrt(input logic [47:0] val);
    logic [25:0] rem;
    logic [25:0] trial;
    logic [23:0] root;
    rem  = 26'h0;
    root = 24'h0;
    for (int i = 23; i >= 0; i--) begin
      rem   = {rem[23:0], val[2*i+1 -: 2]};
      trial = {root, 2'b01};
      if (rem >= trial) begin
        rem  = rem - trial;
        root = {root[22:0], 1'b1};
      end else begin
        root = {root[22:0], 1'b0};
      end
    end
    return root;
  endfunction

  function automatic logic [23:0] thd_calc(input logic [23:0] tot, input logic [23:0] fund);
    logic [47:0] tsq;
    logic [47:0] fsq;
    logic [23:0] root;
    logic [44:0] q;
    tsq  = 48'(tot) * 48'(tot);
    fsq  = 48'(fund) * 48'(fund);
    root = (tsq > fsq) ? isqrt(tsq - fsq) : 24'h0;
    if (fund == 24'h0) begin
      return `THD_CLAMP;
    end
    q = {root, 21'h0} / 45'(fund);
    if (q > 45'(`THD_CLAMP)) begin
      return `THD_CLAMP;
    end
    return q[23:0];
  endfunction

  function automatic logic [15:0] pf_calc(input logic signed [31:0] num,
                                          input logic        [31:0] den,
                                          input logic               sign_neg,
                                          input logic               sat_neg);
    logic [31:0] mag;
    logic [46:0] q;
    logic [15:0] m;
    mag = num[31] ? 32'(-num) : 32'(num);
    if (den == 32'h0) begin
      return sat_neg ? `PF_MINUS_ONE : `PF_PLUS_ONE;
    end
    q = {mag, 15'h0} / 47'(den);
    if (q > 47'h8000) begin
      return sat_neg ? `PF_MINUS_ONE : `PF_PLUS_ONE;
    end
    m = (q >= 47'h7fff) ? `PF_PLUS_ONE : q[15:0];
    if (sign_neg) begin
      return (q >= 47'h7fff) ? `PF_MINUS_ONE : 16'(~m + 16'h0001);
    end
    return m;
  endfunction

  // Configuration and status registers.
  logic [7:0]  apparent_threshold_setting, next_apparent_threshold_setting;
  logic [7:0]  accumulation_mode, next_accumulation_mode;
  logic [15:0] half_cycle_count, next_half_cycle_count;
  logic [15:0] computation_mode, next_computation_mode;
  logic [7:0]  line_cycle_mode, next_line_cycle_mode;
  logic        apparent_half_full_flag, next_apparent_half_full_flag;
  logic        primary_interrupt_mask, next_primary_interrupt_mask;
  logic        next_irq_n;
  logic [31:0] next_reg_rdata;
  logic        next_reg_rvalid;

  // Tick divider and line-cycle counter.
  logic [17:0] tick_phase, next_tick_phase;
  logic [17:0] tick_sum;
  logic        tick;
  logic [15:0] hc_count, next_hc_count;
  logic [16:0] hc_sum;
  logic [2:0]  zx_hits;
  logic [1:0]  zx_inc;
  logic        line_done;

  // Per-phase datapath.
  wiring_t            wiring_selection;
  logic        [23:0] vrms_sel [3];
  logic        [23:0] irms_sel [3];
  logic        [23:0] fund_i_sel [3];
  logic signed [23:0] act_sel [3];
  logic signed [23:0] react_sel [3];
  logic signed [23:0] freact_sel [3];
  logic        [47:0] va_prod [3];
  logic        [27:0] va_now [3];
  logic        [35:0] stage1 [3], next_stage1 [3];
  logic        [35:0] stage1_sum [3];
  logic        [35:0] threshold;
  logic        [2:0]  pulse;
  logic        [31:0] acc2 [3], next_acc2 [3];
  logic        [31:0] energy [3], next_energy [3];
  logic        [31:0] line_energy [3];
  logic        [2:0]  read_clear;
  logic        [2:0]  half_evt;
  logic        [15:0] pf [3], next_pf [3];
  logic        [23:0] thd [6], next_thd [6];
  logic        [23:0] next_b_vrms;
  logic               apparent_line_cycle_enable;
  logic               active_line_cycle_enable;
  logic               pf_line_mode;

  assign wiring_selection = wiring_t'(accumulation_mode[`WIRING_SEL_LSB +: 2]);
  assign apparent_line_cycle_enable = line_cycle_mode[`LCM_APPARENT_LINE_BIT];
  assign active_line_cycle_enable   = line_cycle_mode[`LCM_ACTIVE_LINE_BIT];
  assign pf_line_mode     = line_cycle_mode[`LCM_PF_SOURCE_BIT] & apparent_line_cycle_enable
                            & active_line_cycle_enable;
  assign threshold        = {1'b0, apparent_threshold_setting, 27'h0};

  // Fractional divider: 1024 ticks for every 250000 clocks.
  always_comb begin
    tick_sum        = tick_phase + 18'(`ACC_TICK_KHZ);
    tick            = 1'b0;
    next_tick_phase = tick_sum;
    if (tick_sum >= 18'(`REF_CLK_KHZ)) begin
      tick            = 1'b1;
      next_tick_phase = tick_sum - 18'(`REF_CLK_KHZ);
    end
  end

  // Half line cycle counting over the selected phases.
  always_comb begin
    zx_hits       = zero_cross & line_cycle_mode[`LCM_ZX_SEL_LSB +: 3];
    zx_inc        = {1'b0, zx_hits[0]} + {1'b0, zx_hits[1]} + {1'b0, zx_hits[2]};
    hc_sum        = {1'b0, hc_count} + {15'h0, zx_inc};
    next_hc_count = hc_count;
    line_done     = 1'b0;
    if (!(apparent_line_cycle_enable || active_line_cycle_enable)) begin
      next_hc_count = 16'h0;
    end else if (zx_inc != 2'b00) begin
      if (hc_sum >= {1'b0, half_cycle_count}) begin
        line_done     = 1'b1;
        next_hc_count = 16'h0;
      end else begin
        next_hc_count = hc_sum[15:0];
      end
    end
  end

  // Input selection by wiring and instantaneous apparent power.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      vrms_sel[p]   = phase_in[p].vrms;
      irms_sel[p]   = phase_in[p].irms;
      fund_i_sel[p] = phase_in[p].fund_irms;
      act_sel[p]    = phase_in[p].active;
      react_sel[p]  = phase_in[p].reactive;
      freact_sel[p] = phase_in[p].fund_reactive;
      if (p == 1 && wiring_selection == WIRING_THREE_WIRE) begin
        vrms_sel[p]   = line_ac_rms;
        irms_sel[p]   = 24'h0;
        fund_i_sel[p] = 24'h0;
        act_sel[p]    = 24'sh0;
        react_sel[p]  = 24'sh0;
        freact_sel[p] = 24'sh0;
      end else if (p == 1 && wiring_selection == WIRING_NEG_A) begin
        vrms_sel[p] = phase_in[0].vrms;
      end
      va_prod[p] = 48'(vrms_sel[p]) * 48'(irms_sel[p]);
      va_now[p]  = va_prod[p][`VA_SHIFT +: 28];
    end
    next_b_vrms = dsp_update ? vrms_sel[1] : phase_b_voltage_rms_result;
  end

  // Two-stage accumulation into the energy registers.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      stage1_sum[p]  = stage1[p];
      next_stage1[p] = stage1[p];
      pulse[p]       = 1'b0;
      if (tick) begin
        stage1_sum[p]  = stage1[p] + {8'h0, va_now[p]};
        next_stage1[p] = stage1_sum[p];
        if (stage1_sum[p] >= threshold) begin
          pulse[p]       = 1'b1;
          next_stage1[p] = stage1_sum[p] - threshold;
        end
      end
      read_clear[p]  = reg_rd && reg_addr == ENERGY_ADDR[p]
                       && line_cycle_mode[`LCM_READ_CLEAR_BIT];
      line_energy[p] = acc2[p] + {31'h0, pulse[p]};
      next_acc2[p]   = read_clear[p] ? 32'h0 : acc2[p];
      if (apparent_line_cycle_enable && line_done) begin
        next_acc2[p] = 32'h0;
      end else begin
        next_acc2[p] = next_acc2[p] + {31'h0, pulse[p]};
      end
      next_energy[p] = energy[p];
      if (read_clear[p]) begin
        next_energy[p] = 32'h0;
      end
      if (!apparent_line_cycle_enable) begin
        next_energy[p] = next_acc2[p];
      end else if (line_done) begin
        next_energy[p] = line_energy[p];
      end
      half_evt[p] = next_energy[p][`ENERGY_HALF_BIT] != energy[p][`ENERGY_HALF_BIT];
    end
  end

  // Power factor results.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      next_pf[p] = pf[p];
      if (pf_line_mode && line_done) begin
        next_pf[p] = pf_calc(active_line_energy[p], line_energy[p],
                             reactive_no_load[p] ? active_line_energy[p][31]
                                                 : react_sel[p][23],
                             freact_sel[p][23]);
      end else if (!pf_line_mode && dsp_update) begin
        next_pf[p] = pf_calc(32'(act_sel[p]), {4'h0, va_now[p]},
                             reactive_no_load[p] ? act_sel[p][23] : react_sel[p][23],
                             freact_sel[p][23]);
      end
      if ((pf_line_mode ? line_done : dsp_update) && no_load_enable) begin
        if (apparent_no_load[p]) begin
          next_pf[p] = `PF_PLUS_ONE;
        end else if (active_reactive_no_load[p]) begin
          next_pf[p] = 16'h0000;
        end
      end
    end
  end

  // Harmonic distortion, voltage then current for each phase.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      next_thd[2*p]   = thd[2*p];
      next_thd[2*p+1] = thd[2*p+1];
      if (dsp_update) begin
        next_thd[2*p]   = thd_calc(vrms_sel[p], phase_in[p].fund_vrms);
        next_thd[2*p+1] = thd_calc(irms_sel[p], fund_i_sel[p]);
      end
    end
  end

  // Register writes, status flag and read data.
  always_comb begin
    next_apparent_threshold_setting = apparent_threshold_setting;
    next_accumulation_mode          = accumulation_mode;
    next_half_cycle_count           = half_cycle_count;
    next_computation_mode           = computation_mode;
    next_line_cycle_mode            = line_cycle_mode;
    next_primary_interrupt_mask     = primary_interrupt_mask;
    next_apparent_half_full_flag    = apparent_half_full_flag;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_APPARENT_THRESHOLD:     next_apparent_threshold_setting = reg_wdata[7:0];
        `ADDR_ACCUMULATION_MODE:      next_accumulation_mode          = reg_wdata[7:0];
        `ADDR_HALF_CYCLE_COUNT:       next_half_cycle_count           = reg_wdata[15:0];
        `ADDR_COMPUTATION_MODE:       next_computation_mode           = reg_wdata[15:0];
        `ADDR_LINE_CYCLE_MODE:        next_line_cycle_mode            = reg_wdata[7:0];
        `ADDR_PRIMARY_INTERRUPT_MASK: begin
          next_primary_interrupt_mask = reg_wdata[`STATUS_HALF_FULL_BIT];
        end
        `ADDR_PRIMARY_STATUS: begin
          if (reg_wdata[`STATUS_HALF_FULL_BIT]) begin
            next_apparent_half_full_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A half-full event in the clearing cycle keeps the flag set.
    if (half_evt != 3'b000) begin
      next_apparent_half_full_flag = 1'b1;
    end
    next_irq_n = ~(next_apparent_half_full_flag & next_primary_interrupt_mask);
    next_reg_rvalid = reg_rd;
    next_reg_rdata  = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_PHASE_A_APPARENT_ENERGY:    next_reg_rdata = energy[0];
        `ADDR_PHASE_B_APPARENT_ENERGY:    next_reg_rdata = energy[1];
        `ADDR_PHASE_C_APPARENT_ENERGY:    next_reg_rdata = energy[2];
        `ADDR_PHASE_A_VOLTAGE_DISTORTION: next_reg_rdata = {8'h00, thd[0]};
        `ADDR_PHASE_A_CURRENT_DISTORTION: next_reg_rdata = {8'h00, thd[1]};
        `ADDR_PHASE_B_VOLTAGE_DISTORTION: next_reg_rdata = {8'h00, thd[2]};
        `ADDR_PHASE_B_CURRENT_DISTORTION: next_reg_rdata = {8'h00, thd[3]};
        `ADDR_PHASE_C_VOLTAGE_DISTORTION: next_reg_rdata = {8'h00, thd[4]};
        `ADDR_PHASE_C_CURRENT_DISTORTION: next_reg_rdata = {8'h00, thd[5]};
        `ADDR_PHASE_A_POWER_FACTOR:       next_reg_rdata = {16'h0000, pf[0]};
        `ADDR_PHASE_B_POWER_FACTOR:       next_reg_rdata = {16'h0000, pf[1]};
        `ADDR_PHASE_C_POWER_FACTOR:       next_reg_rdata = {16'h0000, pf[2]};
        `ADDR_APPARENT_THRESHOLD:         next_reg_rdata = {24'h0, apparent_threshold_setting};
        `ADDR_ACCUMULATION_MODE:          next_reg_rdata = {24'h0, accumulation_mode};
        `ADDR_HALF_CYCLE_COUNT:           next_reg_rdata = {16'h0, half_cycle_count};
        `ADDR_COMPUTATION_MODE:           next_reg_rdata = {16'h0, computation_mode};
        `ADDR_LINE_CYCLE_MODE:            next_reg_rdata = {24'h0, line_cycle_mode};
        `ADDR_PRIMARY_STATUS: begin
          next_reg_rdata = 32'({apparent_half_full_flag, 4'h0});
        end
        `ADDR_PRIMARY_INTERRUPT_MASK: begin
          next_reg_rdata = 32'({primary_interrupt_mask, 4'h0});
        end
        default:                          next_reg_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      apparent_threshold_setting <= `RST_THRESHOLD;
      accumulation_mode          <= `RST_ACCUMULATION_MODE;
      half_cycle_count           <= `RST_HALF_CYCLE_COUNT;
      computation_mode           <= `RST_COMPUTATION_MODE;
      line_cycle_mode            <= `RST_LINE_CYCLE_MODE;
      primary_interrupt_mask     <= 1'b0;
      apparent_half_full_flag    <= 1'b0;
      irq_n                      <= 1'b1;
      reg_rdata                  <= 32'h0;
      reg_rvalid                 <= 1'b0;
      tick_phase                 <= 18'h0;
      hc_count                   <= 16'h0;
      apparent_pulse             <= 3'b000;
      phase_b_voltage_rms_result <= 24'h0;
      for (int p = 0; p < 3; p++) begin
        stage1[p] <= 36'h0;
        acc2[p]   <= 32'h0;
        energy[p] <= 32'h0;
        pf[p]     <= 16'h0;
      end
      for (int c = 0; c < 6; c++) begin
        thd[c] <= 24'h0;
      end
    end else begin
      apparent_threshold_setting <= next_apparent_threshold_setting;
      accumulation_mode          <= next_accumulation_mode;
      half_cycle_count           <= next_half_cycle_count;
      computation_mode           <= next_computation_mode;
      line_cycle_mode            <= next_line_cycle_mode;
      primary_interrupt_mask     <= next_primary_interrupt_mask;
      apparent_half_full_flag    <= next_apparent_half_full_flag;
      irq_n                      <= next_irq_n;
      reg_rdata                  <= next_reg_rdata;
      reg_rvalid                 <= next_reg_rvalid;
      tick_phase                 <= next_tick_phase;
      hc_count                   <= next_hc_count;
      apparent_pulse             <= pulse;
      phase_b_voltage_rms_result <= next_b_vrms;
      for (int p = 0; p < 3; p++) begin
        stage1[p] <= next_stage1[p];
        acc2[p]   <= next_acc2[p];
        energy[p] <= next_energy[p];
        pf[p]     <= next_pf[p];
      end
      for (int c = 0; c < 6; c++) begin
        thd[c] <= next_thd[c];
      end
    end
  end

endmodule

// *** apparent_energy_pf_thd_props.sv ***
/* Port assertions for the apparent energy block.
   Assumes a bind to the top module with every port named. */
`timescale 1ns/100ps
`include "apparent_energy_map.svh"
module apparent_energy_pf_thd_props (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        dsp_update,
  input wire logic        irq_n,
  input wire logic [2:0]  apparent_pulse,
  input wire logic [23:0] phase_b_voltage_rms_result
);
  logic [8:0] gap;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Cycles since the last pulse; ticks are never closer than 244 cycles.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) gap <= 9'h1ff;
    else if (apparent_pulse != 3'h0) gap <= 9'h000;
    else if (gap != 9'h1ff) gap <= gap + 9'h001;
  end
  a_read_answers: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_no_stray_answer: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  a_data_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_pulse_single: assert property (apparent_pulse != 3'h0 |=> (apparent_pulse == 3'h0)[*8])
    else $error("pulse too long");
  a_tick_gap: assert property (apparent_pulse != 3'h0 |-> gap >= 9'd240)
    else $error("pulses closer than one tick");
  a_irq_release: assert property ($rose(irq_n) |-> $past(reg_wr))
    else $error("interrupt released without write");
  a_thd_top_zero: assert property (reg_rd && reg_addr >= `ADDR_PHASE_A_VOLTAGE_DISTORTION
    && reg_addr <= `ADDR_PHASE_C_CURRENT_DISTORTION |=> reg_rdata[31:24] == 8'h00)
    else $error("distortion top byte set");
  a_brms_update: assert property (!dsp_update |=> $stable(phase_b_voltage_rms_result))
    else $error("phase b rms moved between updates");
  c_read: cover property (reg_rd ##1 reg_rvalid);
  c_pulse: cover property (apparent_pulse[0]);
  c_update: cover property (dsp_update);
endmodule

// *** test_apparent_energy_pf_thd.sv ***
/* Self-checking bench for the apparent energy block.
   Assumes the package, map header and checker are compiled first. */
`timescale 1ns/100ps
`include "apparent_energy_map.svh"
module test_apparent_energy_pf_thd;
  import apparent_energy_pkg::*;
  logic              ref_clk, reset, reg_wr, reg_rd, reg_rvalid, dsp_update, no_load_enable, irq_n;
  logic [15:0]       reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, d;
  logic [23:0]       line_ac_rms, brms;
  logic [2:0]        zero_cross, apparent_no_load, active_reactive_no_load, apparent_pulse;
  phase_meas_t [2:0] phase_in;
  int                num_errors = 0, tests_run = 0, pulses = 0;
  apparent_energy_pf_thd u_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .dsp_update(dsp_update), .phase_in(phase_in),
    .line_ac_rms(line_ac_rms), .zero_cross(zero_cross), .active_line_energy('0),
    .no_load_enable(no_load_enable), .apparent_no_load(apparent_no_load),
    .active_reactive_no_load(active_reactive_no_load), .reactive_no_load(active_reactive_no_load),
    .irq_n(irq_n), .apparent_pulse(apparent_pulse), .phase_b_voltage_rms_result(brms));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (apparent_pulse[0] === 1'b1) pulses++;
  task automatic check(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge ref_clk) #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk) #1 reg_rd = 1'b0;
    @(posedge ref_clk) #1 d = reg_rdata;
  endtask
  task automatic upd;
    dsp_update = 1'b1;
    @(posedge ref_clk) #1 dsp_update = 1'b0;
    cyc(1);
  endtask
  task automatic zx(input logic [2:0] z);
    zero_cross = z;
    @(posedge ref_clk) #1 zero_cross = 3'h0;
  endtask
  task automatic t_resets;
    logic [15:0] a[6] = '{`ADDR_APPARENT_THRESHOLD, `ADDR_COMPUTATION_MODE, `ADDR_LINE_CYCLE_MODE,
                          `ADDR_ACCUMULATION_MODE, `ADDR_HALF_CYCLE_COUNT, 16'h0000};
    logic [31:0] e[6] = '{`RST_THRESHOLD, `RST_COMPUTATION_MODE, `RST_LINE_CYCLE_MODE,
                          `RST_ACCUMULATION_MODE, `RST_HALF_CYCLE_COUNT, 32'h0};
    foreach (a[i]) begin
      rd(a[i]);
      check("reset value", e[i], d);
    end
    $display("reset test done");
  endtask
  task automatic t_energy;
    phase_in[0].vrms = 24'hffffff;
    phase_in[0].irms = 24'hffffff;
    cyc(3000);
    phase_in[0].vrms = 24'h000000;
    cyc(300);
    rd(`ADDR_PHASE_A_APPARENT_ENERGY);
    check("energy a", pulses, d);
    check("pulses seen", 1, pulses > 4);
    wr(`ADDR_LINE_CYCLE_MODE, 32'h40);
    rd(`ADDR_PHASE_A_APPARENT_ENERGY);
    rd(`ADDR_PHASE_A_APPARENT_ENERGY);
    check("energy after clearing read", 0, d);
    $display("energy test done");
  endtask
  task automatic t_line;
    wr(`ADDR_HALF_CYCLE_COUNT, 32'h2);
    wr(`ADDR_LINE_CYCLE_MODE, 32'h0c);
    phase_in[0].vrms = 24'hffffff;
    cyc(2000);
    rd(`ADDR_PHASE_A_APPARENT_ENERGY);
    check("energy held", 0, d);
    zx(3'b010);
    zx(3'b001);
    rd(`ADDR_PHASE_A_APPARENT_ENERGY);
    check("energy before count", 0, d);
    zx(3'b001);
    cyc(2);
    rd(`ADDR_PHASE_A_APPARENT_ENERGY);
    check("energy at count", 1, d != 0);
    phase_in[0].vrms = 24'h000000;
    $display("line cycle test done");
  endtask
  task automatic t_thd;
    phase_in[0].vrms = 24'h001388;
    phase_in[0].fund_vrms = 24'h000fa0;
    phase_in[0].irms = 24'h001388;
    phase_in[0].fund_irms = 24'h0003e8;
    upd;
    rd(`ADDR_PHASE_A_VOLTAGE_DISTORTION);
    check("voltage distortion", 32'h00180000, d);
    rd(`ADDR_PHASE_A_CURRENT_DISTORTION);
    check("clamped distortion", 32'h007fffff, d);
    $display("distortion test done");
  endtask
  task automatic t_pf;
    logic [15:0] e[3] = '{`PF_MINUS_ONE, `PF_PLUS_ONE, 16'h0000};
    phase_in[0].vrms = 24'h000100;
    phase_in[0].irms = 24'h000100;
    phase_in[0].active = 24'h7fffff;
    phase_in[0].reactive = 24'h000100;
    phase_in[0].fund_reactive = 24'hf00000;
    no_load_enable = 1'b1;
    apparent_no_load = 3'b010;
    active_reactive_no_load = 3'b100;
    upd;
    foreach (e[i]) begin
      rd(`ADDR_PHASE_A_POWER_FACTOR + 16'(i));
      check("power factor", e[i], d[15:0]);
    end
    {no_load_enable, apparent_no_load, active_reactive_no_load} = '0;
    $display("power factor test done");
  endtask
  task automatic t_wiring;
    logic [23:0] e[4] = '{24'h222222, 24'h333333, 24'h222222, 24'h111111};
    phase_in[0].vrms = 24'h111111;
    phase_in[1].vrms = 24'h222222;
    line_ac_rms = 24'h333333;
    wr(`ADDR_COMPUTATION_MODE, 32'h016d);
    for (int w = 0; w < 4; w++) begin
      wr(`ADDR_ACCUMULATION_MODE, 32'(w) << `WIRING_SEL_LSB);
      upd;
      check("phase b voltage", e[w], brms);
    end
    check("interrupt line", 1, irq_n);
    $display("wiring test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {ref_clk, reg_wr, reg_rd, dsp_update, no_load_enable} = '0;
    {reg_addr, reg_wdata, line_ac_rms, zero_cross, apparent_no_load, active_reactive_no_load} = '0;
    phase_in = '0;
    reset = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'b0;
    t_resets;
    t_energy;
    t_line;
    t_thd;
    t_pf;
    t_wiring;
    conclude;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    conclude;
  end
endmodule
bind apparent_energy_pf_thd apparent_energy_pf_thd_props u_props (.ref_clk(ref_clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .dsp_update(dsp_update), .irq_n(irq_n),
  .apparent_pulse(apparent_pulse), .phase_b_voltage_rms_result(phase_b_voltage_rms_result));
